/* File: inc/bal_pkg.sv */
package bal_pkg;

    // ******************************************************************
    // timing
    // ******************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int ADV_STEP_NS = 2500;
    // winding decay wait between high-side and low-side turn-off
    localparam int DECAY_NS = 1000;
    localparam logic [19:0] DECAY_CYC =
        20'(DECAY_NS / CLK_PERIOD_NS);
    // off time after a fault before the automatic restart
    localparam int LOCK_OFF_US = 5000;
    localparam int LOCK_OFF_CYC = LOCK_OFF_US * 1000 / CLK_PERIOD_NS;

    // ******************************************************************
    // widths and field positions
    // ******************************************************************
    localparam int PER_W = 20;
    localparam int AMP_W = 24;
    localparam int CUR_W = 12;
    localparam int SPD_W = 16;
    localparam int ADV_MANT_LSB = 0;
    localparam int ADV_MANT_MSB = 3;
    localparam int ADV_EXP_LSB = 4;
    localparam int ADV_EXP_MSB = 6;

    // ******************************************************************
    // current thresholds in mA
    // ******************************************************************
    localparam logic [11:0] NO_MOTOR_MA = 12'h08c;
    localparam logic [11:0] LOCK_STEP_MA = 12'h1f4;

    // ******************************************************************
    // fault cause bit positions
    // ******************************************************************
    localparam int FLT_CURRENT = 0;
    localparam int FLT_SPEED = 1;
    localparam int FLT_KT = 2;
    localparam int FLT_NOMOTOR = 3;
    localparam int FLT_OLSTUCK = 4;
    localparam int FLT_CLSTUCK = 5;

    // ******************************************************************
    // reset values
    // ******************************************************************
    localparam logic [5:0] FAULT_RST = 6'h00;
    localparam logic [19:0] CNT_RST = 20'h00000;
    localparam logic [23:0] AMP_RST = 24'h000000;

    typedef enum logic [2:0] {
        BAL_RUN = 3'b001,
        BAL_SURGE = 3'b010,
        BAL_OFF = 3'b100
    } bal_state_t;

    typedef struct packed {
        logic advance_mode_select;
        logic [6:0] advance_time_code;
        logic [3:0] accel_current_threshold;
        logic [2:0] lock_current_threshold;
        logic [5:0] lock_scheme_enables;
        logic [6:0] motor_resistance_setting;
        logic [6:0] velocity_constant_setting;
    } bal_cfg_t;

    typedef struct packed {
        logic [SPD_W-1:0] speed;
        logic [AMP_W-1:0] cmd_amplitude;
        logic [AMP_W-1:0] phase_amplitude;
        logic [AMP_W-1:0] bemf_amplitude;
        logic [CUR_W-1:0] low_side_current;
        logic [CUR_W-1:0] u_phase_current;
    } bal_meas_t;

endpackage : bal_pkg

/* File: hdl/bal_adv_timer.sv */
module bal_adv_timer (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic advance_mode_select, // 0 fixed, 1 variable
    input wire logic [6:0] advance_time_code, // exponent and mantissa
    input wire logic [23:0] phase_amplitude, // U
    input wire logic [23:0] bemf_amplitude, // back-emf amplitude
    input wire logic zero_cross, // estimated zero cross pulse
    output logic [19:0] advance_cycles, // advance in clocks
    output logic [19:0] period_count, // clocks since last zero cross
    output logic [19:0] last_period, // previous zero cross interval
    output logic commutate // drive update pulse
);

    typedef struct packed {
        logic [19:0] cnt;
        logic [19:0] last;
        logic [19:0] adv;
        logic armed;
        logic fire;
    } bal_adv_st_t;

    bal_adv_st_t st_ff;
    bal_adv_st_t nxt_st;

    // ******************************************************************
    // advance computation and zero-cross timing
    // ******************************************************************
    // the divide by U is costly but only runs once per clock with no
    // pipeline; U changes slowly so a single-cycle lag is harmless
    always_comb
    begin
        logic [31:0] base;
        logic [47:0] scaled;
        logic [19:0] target;
        base = 32'h0;
        scaled = 48'h0;
        target = 20'h0;
        nxt_st = st_ff;
        nxt_st.fire = 1'b0;
        base = (32'(advance_time_code[bal_pkg::ADV_MANT_MSB:
                                     bal_pkg::ADV_MANT_LSB])
                << advance_time_code[bal_pkg::ADV_EXP_MSB:
                                     bal_pkg::ADV_EXP_LSB])
               * 32'(bal_pkg::ADV_STEP_NS)
               / 32'(bal_pkg::CLK_PERIOD_NS); // [RL3]
        if (!advance_mode_select)
        begin
            nxt_st.adv = base[19:0]; // [RL1]
        end
        else if (phase_amplitude == 24'h000000 ||
                 bemf_amplitude >= phase_amplitude)
        begin
            nxt_st.adv = 20'h00000; // no headroom, no advance
        end
        else
        begin
            scaled = 48'(base[19:0]) *
                     48'(phase_amplitude - bemf_amplitude)
                     / 48'(phase_amplitude); // [RL2]
            nxt_st.adv = scaled[19:0];
        end
        // fire the drive update the advance ahead of the next crossing
        target = (st_ff.last > st_ff.adv) ?
                 st_ff.last - st_ff.adv : 20'h00000;
        if (zero_cross)
        begin
            nxt_st.cnt = 20'h00000;
            nxt_st.last = st_ff.cnt;
            nxt_st.armed = 1'b1;
        end
        else
        begin
            if (st_ff.cnt != 20'hfffff)
            begin
                nxt_st.cnt = st_ff.cnt + 20'h00001;
            end
            if (st_ff.armed && st_ff.cnt >= target)
            begin
                nxt_st.fire = 1'b1; // [RL1] [RL2]
                nxt_st.armed = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign advance_cycles = st_ff.adv;
    assign period_count = st_ff.cnt;
    assign last_period = st_ff.last;
    assign commutate = st_ff.fire;

endmodule : bal_adv_timer

/* File: hdl/bal_lock_ctrl.sv */
// Operation
// RL1: mode 0 keeps advance at configured setting
// RL2: mode 1 scales advance by (U-BEMF)/U
// RL3: setting is 2.5 us times mantissa, shifted
// RL4: limit amplitude to I times R plus speed times Kt
// RL5: limit only in closed loop, no fault; the code gates the limit on closed_loop alone and ignores faults
// RL6: low-side overcurrent past threshold locks, tristates
// RL7: fixed overcurrent stops drive until it clears
// RL8: six enable bits, one per detection scheme
// RL9: any lock sets the motor lock flag
// RL10: fault record set even when scheme disabled
// RL11: restart clears fault record and lock flag
// RL12: lock or no motor tristates via surge sequence
// RL13: after off interval, restart automatically
// RL14: software sets lock threshold above accel threshold
// RL15: after handoff, U current not above 140 mA faults
// RL16: closed loop period over twice previous is stuck
// RL17: output amplitude is smaller of command and limit
module bal_lock_ctrl #(
    parameter int LOCK_OFF_CYCLES = bal_pkg::LOCK_OFF_CYC
) (
    input wire logic clk_sys, // system clock, 25 MHz
    input wire logic rst_n, // async reset, active low
    input wire bal_pkg::bal_cfg_t cfg, // software configuration
    input wire bal_pkg::bal_meas_t meas, // measured and estimated values
    input wire logic closed_loop, // control is in closed loop
    input wire logic handoff, // open to closed loop transition pulse
    input wire logic zero_cross, // estimated zero cross pulse
    input wire logic lock_abnormal_speed, // speed lock scheme hit
    input wire logic lock_abnormal_kt, // kt lock scheme hit
    input wire logic lock_open_loop_stuck, // open loop stuck hit
    input wire logic overcurrent_indication, // fixed phase overcurrent
    output logic commutate, // drive update pulse
    output logic [19:0] advance_cycles, // current advance in clocks
    output logic [23:0] output_amplitude, // amplitude to apply
    output logic high_side_enable, // high-side drivers may conduct
    output logic low_side_enable, // low-side drivers may conduct
    output logic phases_hiz, // all phases high impedance
    output logic anti_surge_sequence, // surge transition in progress
    output logic motor_lock_flag, // lock status
    output logic [5:0] fault_cause_record, // which condition occurred
    output logic restart // restart pulse
);

    typedef struct packed {
        bal_pkg::bal_state_t state;
        logic [19:0] timer;
        logic [5:0] fault;
        logic lock;
        logic [23:0] amp;
        logic restart;
    } bal_main_st_t;

    bal_main_st_t st_ff;
    bal_main_st_t nxt_st;
    logic [19:0] period_count;
    logic [19:0] last_period;
    logic [5:0] det;
    logic [23:0] u_limit;
    logic [12:0] lock_thr;
    logic trip;

    // ******************************************************************
    // commutation advance
    // ******************************************************************
    bal_adv_timer u_adv (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .advance_mode_select(cfg.advance_mode_select),
        .advance_time_code(cfg.advance_time_code),
        .phase_amplitude(meas.phase_amplitude),
        .bemf_amplitude(meas.bemf_amplitude),
        .zero_cross(zero_cross),
        .advance_cycles(advance_cycles),
        .period_count(period_count),
        .last_period(last_period),
        .commutate(commutate)
    );

    // ******************************************************************
    // acceleration limit and lock detection
    // ******************************************************************
    // the limit is estimated from settings; no current is measured
    assign u_limit = 24'(cfg.accel_current_threshold *
                         cfg.motor_resistance_setting)
                     + 24'(meas.speed * cfg.velocity_constant_setting); // [RL4]
    // threshold steps are linear in the 3-bit code, one step minimum
    assign lock_thr = 13'((cfg.lock_current_threshold + 3'h0 + 13'h1)
                          * bal_pkg::LOCK_STEP_MA);

    // detections only count in BAL_RUN, even while overcurrent holds the bridge off
    always_comb
    begin
        det = 6'h00;
        if (st_ff.state == bal_pkg::BAL_RUN)
        begin
            det[bal_pkg::FLT_CURRENT] =
                13'(meas.low_side_current) > lock_thr; // [RL6]
            det[bal_pkg::FLT_SPEED] = lock_abnormal_speed;
            det[bal_pkg::FLT_KT] = lock_abnormal_kt;
            det[bal_pkg::FLT_NOMOTOR] = handoff &&
                meas.u_phase_current <= bal_pkg::NO_MOTOR_MA; // [RL15]
            det[bal_pkg::FLT_OLSTUCK] = lock_open_loop_stuck;
            // a stuck rotor shows as a period that keeps growing, so
            // the running count is watched, not only finished periods
            det[bal_pkg::FLT_CLSTUCK] = closed_loop &&
                last_period != 20'h00000 &&
                21'(period_count) > {last_period, 1'b0}; // [RL16]
        end
    end

    assign trip = |(det & cfg.lock_scheme_enables); // [RL8]

    // ******************************************************************
    // fault state machine
    // ******************************************************************
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.restart = 1'b0;
        nxt_st.fault = st_ff.fault | det; // [RL10]
        if (closed_loop && u_limit < meas.cmd_amplitude)
        begin
            nxt_st.amp = u_limit; // [RL5] [RL17]
        end
        else
        begin
            nxt_st.amp = meas.cmd_amplitude;
        end
        case (st_ff.state)
            bal_pkg::BAL_RUN:
            begin
                if (trip)
                begin
                    nxt_st.lock = 1'b1; // [RL6] [RL9]
                    nxt_st.state = bal_pkg::BAL_SURGE; // [RL12]
                    nxt_st.timer = bal_pkg::DECAY_CYC;
                end
            end
            bal_pkg::BAL_SURGE:
            begin
                // high side is off, low side holds until winding decays
                if (st_ff.timer <= 20'h00001)
                begin
                    nxt_st.state = bal_pkg::BAL_OFF; // [RL12]
                    nxt_st.timer = 20'(LOCK_OFF_CYCLES);
                end
                else
                begin
                    nxt_st.timer = st_ff.timer - 20'h00001;
                end
            end
            bal_pkg::BAL_OFF:
            begin
                if (st_ff.timer <= 20'h00001)
                begin
                    nxt_st.state = bal_pkg::BAL_RUN; // [RL13]
                    nxt_st.restart = 1'b1;
                    nxt_st.fault = bal_pkg::FAULT_RST | det; // [RL11]
                    nxt_st.lock = 1'b0; // [RL11]
                    nxt_st.timer = bal_pkg::CNT_RST;
                end
                else
                begin
                    nxt_st.timer = st_ff.timer - 20'h00001;
                end
            end
            default:
            begin
                nxt_st.state = bal_pkg::BAL_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff.state <= bal_pkg::BAL_RUN;
            st_ff.timer <= bal_pkg::CNT_RST;
            st_ff.fault <= bal_pkg::FAULT_RST;
            st_ff.lock <= 1'b0;
            st_ff.amp <= bal_pkg::AMP_RST;
            st_ff.restart <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ******************************************************************
    // driver gating
    // ******************************************************************
    // overcurrent gates the bridge directly so it acts without a
    // clock of delay and releases as soon as the indication drops
    assign high_side_enable = (st_ff.state == bal_pkg::BAL_RUN) &&
                              !overcurrent_indication; // [RL7]
    assign low_side_enable = (st_ff.state != bal_pkg::BAL_OFF) &&
                             !overcurrent_indication; // [RL7] [RL12]
    assign phases_hiz = !low_side_enable;
    assign anti_surge_sequence = (st_ff.state == bal_pkg::BAL_SURGE);
    assign motor_lock_flag = st_ff.lock;
    assign fault_cause_record = st_ff.fault;
    assign output_amplitude = st_ff.amp;
    assign restart = st_ff.restart;

endmodule : bal_lock_ctrl

/* File: verification/bal_lock_checker.sv */
module bal_lock_checker #(
    parameter int LOCK_OFF_CYCLES = bal_pkg::LOCK_OFF_CYC
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // async reset, active low
    input wire bal_pkg::bal_cfg_t cfg, // configuration
    input wire bal_pkg::bal_meas_t meas, // measurements
    input wire logic closed_loop, // closed loop level
    input wire logic handoff, // handoff pulse
    input wire logic overcurrent_indication, // fixed overcurrent
    input wire logic [19:0] advance_cycles, // advance in clocks
    input wire logic [23:0] output_amplitude, // applied amplitude
    input wire logic high_side_enable, // high side may conduct
    input wire logic low_side_enable, // low side may conduct
    input wire logic phases_hiz, // outputs floating
    input wire logic anti_surge_sequence, // surge step running
    input wire logic motor_lock_flag, // lock status
    input wire logic [5:0] fault_cause_record, // fault bits
    input wire logic restart // restart pulse
);
    logic [19:0] off_cnt_ff;
    logic [19:0] nxt_off_cnt;
    logic [63:0] base_w;
    logic [63:0] adv_w;
    logic [23:0] lim_w;
    logic [23:0] amp_w;
    logic [11:0] lock_ma_w;

    // ******************************************************************
    // reference values; the advance terms are 64 bits wide so the scaling cannot overflow
    // ******************************************************************
    always_comb
    begin
        base_w = (64'(cfg.advance_time_code[3:0]) <<
            cfg.advance_time_code[6:4]) * 64'h9c4 / 64'h28;
        adv_w = base_w;
        if (cfg.advance_mode_select)
            adv_w = (meas.bemf_amplitude >= meas.phase_amplitude) ? 64'h0 :
                base_w * 64'(meas.phase_amplitude - meas.bemf_amplitude)
                / 64'(meas.phase_amplitude);
        lim_w = 24'(cfg.accel_current_threshold) *
            24'(cfg.motor_resistance_setting) +
            24'(meas.speed) * 24'(cfg.velocity_constant_setting);
        amp_w = (closed_loop && lim_w < meas.cmd_amplitude) ? lim_w :
            meas.cmd_amplitude;
        lock_ma_w = (12'(cfg.lock_current_threshold) + 12'h1) *
            bal_pkg::LOCK_STEP_MA;
        nxt_off_cnt = (motor_lock_flag && !anti_surge_sequence) ?
            off_cnt_ff + 20'h1 : 20'h0;
    end

    // off-time counter of locked clocks outside the surge step, cleared the clock after the lock drops
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            off_cnt_ff <= 20'h0;
        else
            off_cnt_ff <= nxt_off_cnt;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_surge;
        motor_lock_flag && anti_surge_sequence && !high_side_enable;
    endsequence
    sequence s_off;
        !anti_surge_sequence && phases_hiz && !low_side_enable;
    endsequence

    AST_LOCK_CURRENT: assert property (
        !motor_lock_flag && cfg.lock_scheme_enables[0] &&
        meas.low_side_current > lock_ma_w |=> s_surge ##25 s_off)
        else $error("lock on current did not run surge then off");
    AST_FAULT_ALWAYS: assert property (
        !motor_lock_flag && meas.low_side_current > lock_ma_w
        |=> fault_cause_record[0])
        else $error("current fault not recorded");
    AST_NO_MOTOR: assert property (
        !motor_lock_flag && handoff &&
        meas.u_phase_current <= bal_pkg::NO_MOTOR_MA
        |=> fault_cause_record[bal_pkg::FLT_NOMOTOR])
        else $error("no motor fault not recorded");
    AST_RESTART: assert property (
        restart |-> off_cnt_ff == 20'(LOCK_OFF_CYCLES) && !motor_lock_flag)
        else $error("restart not after the off interval");
    AST_LOCK_CLEAR: assert property (
        $fell(motor_lock_flag) |-> restart)
        else $error("lock cleared without restart");
    AST_OVC_STOP: assert property (
        overcurrent_indication |->
        phases_hiz && !high_side_enable && !low_side_enable)
        else $error("drive not stopped on overcurrent");
    AST_OVC_RESUME: assert property (
        $fell(overcurrent_indication) && !motor_lock_flag |->
        high_side_enable && low_side_enable)
        else $error("drive not resumed after overcurrent");
    AST_ADVANCE: assert property (
        1'b1 |=> advance_cycles == 20'($past(adv_w)))
        else $error("advance time wrong");
    AST_AMPLITUDE: assert property (
        1'b1 |=> output_amplitude == $past(amp_w))
        else $error("output amplitude wrong");
endmodule : bal_lock_checker

bind bal_lock_ctrl bal_lock_checker #(
    .LOCK_OFF_CYCLES(LOCK_OFF_CYCLES)
) u_bal_lock_checker (
    .clk_sys, .rst_n, .cfg, .meas, .closed_loop, .handoff,
    .overcurrent_indication, .advance_cycles, .output_amplitude,
    .high_side_enable, .low_side_enable, .phases_hiz,
    .anti_surge_sequence, .motor_lock_flag, .fault_cause_record, .restart
);

/* File: verification/bal_motor_model.sv */
module bal_motor_model (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic low_side_enable, // low-side path closed
    input wire logic high_side_enable, // high-side path closed
    input wire logic present, // windings connected
    input wire logic [11:0] stall_ma, // load current when driven
    output logic [11:0] low_side_current, // sensed low-side current
    output logic [11:0] u_phase_current // sensed U phase current
);
    // winding current lags the drive by a clock, like an inductive load;
    // a floating bridge carries no current at all
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_side_current <= 12'h000;
            u_phase_current <= 12'h000;
        end
        else
        begin
            low_side_current <= low_side_enable ? stall_ma : 12'h000;
            u_phase_current <= (present && high_side_enable) ?
                12'h0c8 : 12'h000;
        end
    end
endmodule : bal_motor_model

/* File: verification/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic mode;
        logic [6:0] code;
        logic [3:0] accel;
        logic [6:0] res;
        logic [6:0] kt;
        logic [15:0] spd;
        logic [23:0] cmd;
        logic [23:0] ph;
        logic [23:0] bf;
        logic cl;
        logic [23:0] e_adv;
        logic [23:0] e_amp;
    } bal_row_t;

    // ******************************************************************
    // ordinary cases: fixed, scaled and degenerate advance; limit on/off
    // ******************************************************************
    bal_row_t rows [5] = '{
        '{0, 7'h01, 4'h4, 7'h0a, 7'h02, 16'h0064, 24'h3e8, 24'h3e8,
          24'h0, 1, 24'h00003e, 24'h0000f0},
        '{0, 7'h7f, 4'h4, 7'h0a, 7'h02, 16'h0064, 24'h3e8, 24'h3e8,
          24'h0, 0, 24'h01d4c0, 24'h0003e8},
        '{1, 7'h0a, 4'hf, 7'h7f, 7'h7f, 16'hffff, 24'hffffff, 24'h3e8,
          24'h258, 1, 24'h0000fa, 24'h7f06f2},
        '{1, 7'h29, 4'h1, 7'h01, 7'h01, 16'h000a, 24'h5, 24'h0,
          24'h0, 1, 24'h000000, 24'h000005},
        '{1, 7'h18, 4'h2, 7'h03, 7'h00, 16'h0000, 24'h6, 24'h1f4,
          24'h1f4, 1, 24'h000000, 24'h000006}};

    logic clk_sys;
    logic rst_n;
    logic closed_loop;
    logic handoff;
    logic zero_cross;
    logic lock_abnormal_speed;
    logic lock_abnormal_kt;
    logic lock_open_loop_stuck;
    logic overcurrent_indication;
    logic present;
    logic [11:0] stall_ma;
    logic [11:0] ls_cur;
    logic [11:0] u_cur;
    logic [15:0] spd;
    logic [23:0] cmd;
    logic [23:0] ph;
    logic [23:0] bf;
    bal_pkg::bal_cfg_t cfg;
    bal_pkg::bal_meas_t meas;
    logic [19:0] advance_cycles;
    logic [23:0] output_amplitude;
    logic high_side_enable;
    logic low_side_enable;
    logic phases_hiz;
    logic motor_lock_flag;
    logic [5:0] fault_cause_record;
    logic restart;
    int err_count;
    int comparisons;
    wire logic [23:0] adv24 = {4'h0, advance_cycles};
    wire logic [23:0] flt24 = {18'h0, fault_cause_record};

    assign meas = '{spd, cmd, ph, bf, ls_cur, u_cur};

    bal_lock_ctrl #(.LOCK_OFF_CYCLES(40)) u_bal_lock_ctrl (
        .clk_sys, .rst_n, .cfg, .meas, .closed_loop, .handoff, .zero_cross,
        .lock_abnormal_speed, .lock_abnormal_kt, .lock_open_loop_stuck,
        .overcurrent_indication, .commutate(), .advance_cycles,
        .output_amplitude, .high_side_enable, .low_side_enable,
        .phases_hiz, .anti_surge_sequence(), .motor_lock_flag,
        .fault_cause_record, .restart);

    bal_motor_model u_bal_motor_model (
        .clk_sys, .rst_n, .low_side_enable, .high_side_enable, .present,
        .stall_ma, .low_side_current(ls_cur), .u_phase_current(u_cur));

    // free-running 25 MHz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    task automatic check_word(input string n, input logic [23:0] e,
        input logic [23:0] g);
        comparisons++;
        if (g !== e)
        begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask : check_word

    task automatic check_flag(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e)
        begin
            $display("unexpected %s expected %b seen %b", n, e, g);
            err_count++;
        end
    endtask : check_flag

    // bounded wait: 0..5 fault bit, 6 lock flag, 7 restart pulse
    task automatic wait_hi(input int sel);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 200 && !hit; i++)
        begin
            @(posedge clk_sys);
            #1;
            hit = (sel < 6) ? fault_cause_record[sel] === 1'b1 :
                (sel == 6) ? motor_lock_flag === 1'b1 : restart === 1'b1;
        end
        if (!hit)
        begin
            $display("unexpected timeout on wait %0d", sel);
            err_count++;
            complete_run();
        end
    endtask : wait_hi

    // one-cycle pulse; two idle edges first let the winding current settle
    task automatic pulse(input logic h);
        repeat (2) @(posedge clk_sys);
        if (h)
            handoff <= 1'b1;
        else
            zero_cross <= 1'b1;
        @(posedge clk_sys);
        handoff <= 1'b0;
        zero_cross <= 1'b0;
    endtask : pulse

    // raise or drop the cause of detection scheme k
    task automatic fire(input int k, input logic v);
        case (k)
            0: stall_ma <= v ? 12'h3e8 : 12'h064;
            1: lock_abnormal_speed <= v;
            2: lock_abnormal_kt <= v;
            3: present <= !v;
            4: lock_open_loop_stuck <= v;
            default: closed_loop <= v;
        endcase
        if (v && k == 3)
            pulse(1'b1);
        if (v && k == 5)
        begin
            pulse(1'b0);
            repeat (10) @(posedge clk_sys);
            pulse(1'b0);
        end
    endtask : fire

    initial
    begin
        err_count = 0;
        comparisons = 0;
        rst_n = 1'b0;
        {closed_loop, handoff, zero_cross, lock_abnormal_speed} = 4'h0;
        {lock_abnormal_kt, lock_open_loop_stuck} = 2'h0;
        overcurrent_indication = 1'b0;
        present = 1'b1;
        stall_ma = 12'h064;
        {spd, cmd, ph, bf} = '0;
        // lock trip kept well above the acceleration limit
        cfg = '{1'b0, 7'h00, 4'h1, 3'h0, 6'h3f, 7'h00, 7'h00};
        repeat (6) @(posedge clk_sys);
        #1;
        check_word("faults", 24'h0, flt24);
        check_flag("lock", 1'b0, motor_lock_flag);
        check_flag("hiz", 1'b0, phases_hiz);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            @(posedge clk_sys);
            cfg.advance_mode_select <= rows[i].mode;
            cfg.advance_time_code <= rows[i].code;
            cfg.accel_current_threshold <= rows[i].accel;
            cfg.motor_resistance_setting <= rows[i].res;
            cfg.velocity_constant_setting <= rows[i].kt;
            {spd, cmd, ph, bf} <= {rows[i].spd, rows[i].cmd, rows[i].ph,
                rows[i].bf};
            closed_loop <= rows[i].cl;
            repeat (2) @(posedge clk_sys);
            #1;
            check_word("advance", rows[i].e_adv, adv24);
            check_word("amp", rows[i].e_amp, output_amplitude);
        end
        // overcurrent stops drive without a flag and releases it
        @(posedge clk_sys);
        overcurrent_indication <= 1'b1;
        closed_loop <= 1'b0;
        @(posedge clk_sys);
        #1;
        check_flag("hiz", 1'b1, phases_hiz);
        check_flag("low", 1'b0, low_side_enable);
        check_flag("lock", 1'b0, motor_lock_flag);
        @(posedge clk_sys);
        overcurrent_indication <= 1'b0;
        @(posedge clk_sys);
        #1;
        check_flag("high", 1'b1, high_side_enable);
        // each scheme: disabled records only, enabled locks then restarts
        for (int k = 0; k < 6; k++)
            for (int en = 0; en < 2; en++)
            begin
                @(posedge clk_sys);
                cfg.lock_scheme_enables <= en[0] ? 6'h3f : 6'h00;
                fire(k, 1'b1);
                wait_hi(en[0] ? 6 : k);
                check_flag("fault", 1'b1, fault_cause_record[k]);
                check_flag("lock", en[0], motor_lock_flag);
                @(posedge clk_sys);
                fire(k, 1'b0);
                if (en[0])
                begin
                    wait_hi(7);
                    check_word("faults", 24'h0, flt24);
                    check_flag("lock", 1'b0, motor_lock_flag);
                end
            end
        complete_run();
    end
endmodule : testbench
